// ### logic/fbest_pkg.sv
// constants shared by the error status and timer register slice
package fbest_pkg;

   // ------------------------------------------------------------
   // register offsets on the host bus
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_TIMER_STATUS = 12'h006;
   localparam logic [ADDR_W-1:0] ADDR_ERROR_STATUS = 12'h01E;
   localparam logic [ADDR_W-1:0] ADDR_SNAPSHOT = 12'h01F;
   localparam logic [ADDR_W-1:0] ADDR_FINE_HI = 12'h020;
   localparam logic [ADDR_W-1:0] ADDR_FINE_LO = 12'h021;
   localparam logic [ADDR_W-1:0] ADDR_MS_HI = 12'h022;
   localparam logic [ADDR_W-1:0] ADDR_MS_LO = 12'h023;
   localparam logic [ADDR_W-1:0] ADDR_BYTE_HI = 12'h024;
   localparam logic [ADDR_W-1:0] ADDR_BYTE_LO = 12'h025;

   // ------------------------------------------------------------
   // receive_error_status field positions
   // ------------------------------------------------------------
   localparam int POLARITY_REVERSED_STATUS_BIT = 7;
   localparam int TABLE_SEARCH_ACTIVE_STATUS_BIT = 6;
   localparam int CARRIER_LOST_STATUS_BIT = 4;
   localparam int OVERLENGTH_FRAME_STATUS_BIT = 3;
   localparam int LINE_CODE_ERROR_STATUS_BIT = 2;
   localparam int MISSING_END_DELIMITER_STATUS_BIT = 1;
   localparam int MISSING_START_DELIMITER_STATUS_BIT = 0;

   // ------------------------------------------------------------
   // timer_interrupt_status field positions (channel i: 2i, 2i+1)
   // ------------------------------------------------------------
   localparam int FINE_TIMER_WRAP_FLAG_BIT = 0;
   localparam int FINE_TIMER_COMPARE_FLAG_BIT = 1;
   localparam int MILLISECOND_WRAP_FLAG_BIT = 2;
   localparam int MILLISECOND_COMPARE_FLAG_BIT = 3;
   localparam int BYTE_TIMER_WRAP_FLAG_BIT = 4;
   localparam int BYTE_TIMER_COMPARE_FLAG_BIT = 5;
   localparam int FLAG_W = 6;

   // ------------------------------------------------------------
   // timers
   // ------------------------------------------------------------
   localparam int NUM_TIMERS = 3;
   localparam int TIMER_FINE = 0;
   localparam int TIMER_MS = 1;
   localparam int TIMER_BYTE = 2;
   localparam int PRESCALE_W = 17;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COMPARE_RESET = 16'h0000;
   localparam logic [15:0] COUNT_WRAP = 16'hFFFF;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ------------------------------------------------------------
   // timing: tick periods in ns, cycles derived from the clock
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int FINE_PERIOD_NS = 31250;
   localparam int MS_PERIOD_NS = 1000000;
   // one octet at 31.25 kbit/s is 8 bit times of 32 us
   localparam int BYTE_PERIOD_NS = 256000;
   localparam int FINE_TICK_CYCLES = FINE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MS_TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam int BYTE_TICK_CYCLES = BYTE_PERIOD_NS / CLK_PERIOD_NS;

endpackage

// ### logic/fbest_timer_if.sv
// carrier between the register decode and the timer bank
`timescale 1ns/1ps
interface fbest_timer_if;
   import fbest_pkg::*;

   logic [NUM_TIMERS-1:0][15:0] count;
   logic [FLAG_W-1:0] flags;
   logic [NUM_TIMERS-1:0] compare_we;
   logic compare_high;
   logic [7:0] wdata;
   logic [FLAG_W-1:0] flag_clear;

   modport regs (
      input count,
      input flags,
      output compare_we,
      output compare_high,
      output wdata,
      output flag_clear
   );

   modport bank (
      output count,
      output flags,
      input compare_we,
      input compare_high,
      input wdata,
      input flag_clear
   );
endinterface

// ### logic/fbest_timer_bank.sv
// three free-running data-link timers with compare and wrap flags
`timescale 1ns/1ps
module fbest_timer_bank #(
   parameter int MS_CYCLES = fbest_pkg::MS_TICK_CYCLES,
   parameter int BYTE_CYCLES = fbest_pkg::BYTE_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // register side
   fbest_timer_if.bank tif
);
   import fbest_pkg::*;

   for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
      localparam int LIMIT_INT = (i == TIMER_FINE) ? FINE_TICK_CYCLES :
                                 (i == TIMER_MS) ? MS_CYCLES : BYTE_CYCLES;
      localparam logic [PRESCALE_W-1:0] LAST =
         PRESCALE_W'(LIMIT_INT - 1);

      logic [PRESCALE_W-1:0] pre_reg;
      logic [15:0] count_reg;
      logic [15:0] compare_reg;
      logic match_prev_reg;
      logic wrap_prev_reg;
      logic compare_flag_reg;
      logic wrap_flag_reg;
      logic match_now;
      logic wrap_now;
      logic tick;

      assign tick = (pre_reg == LAST);
      assign match_now = (count_reg == compare_reg);
      assign wrap_now = (count_reg == COUNT_WRAP);

      // -------------------------------------------------------
      // prescaler and count
      // -------------------------------------------------------
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            pre_reg <= '0;
         end else if (clk_en) begin
            pre_reg <= tick ? '0 : pre_reg + 1'b1;
         end
      end

      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            count_reg <= COUNT_RESET;
         end else if (clk_en && tick) begin
            count_reg <= count_reg + 16'h0001;
         end
      end

      // compare value, loaded one byte at a time
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            compare_reg <= COMPARE_RESET;
         end else if (clk_en && tif.compare_we[i]) begin
            if (tif.compare_high) begin
               compare_reg[15:8] <= tif.wdata;
            end else begin
               compare_reg[7:0] <= tif.wdata;
            end
         end
      end

      // -------------------------------------------------------
      // flags: set on entering a match, so a clear sticks while
      // the count dwells on the value; set beats clear
      // -------------------------------------------------------
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            match_prev_reg <= 1'b0;
            wrap_prev_reg <= 1'b0;
         end else if (clk_en) begin
            match_prev_reg <= match_now;
            wrap_prev_reg <= wrap_now;
         end
      end

      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            compare_flag_reg <= 1'b0;
         end else if (clk_en) begin
            if (match_now && !match_prev_reg) begin
               compare_flag_reg <= 1'b1;
            end else if (tif.flag_clear[2*i+1]) begin
               compare_flag_reg <= 1'b0;
            end
         end
      end

      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            wrap_flag_reg <= 1'b0;
         end else if (clk_en) begin
            if (wrap_now && !wrap_prev_reg) begin
               wrap_flag_reg <= 1'b1;
            end else if (tif.flag_clear[2*i]) begin
               wrap_flag_reg <= 1'b0;
            end
         end
      end

      assign tif.count[i] = count_reg;
      assign tif.flags[2*i+1:2*i] = {compare_flag_reg, wrap_flag_reg};
   end

endmodule

// ### logic/fbest_regs.sv
// error status and timer register slice of the fieldbus controller
`timescale 1ns/1ps
module fbest_regs #(
   parameter int MS_CYCLES = fbest_pkg::MS_TICK_CYCLES,
   parameter int BYTE_CYCLES = fbest_pkg::BYTE_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // host register bus
   input wire logic [fbest_pkg::ADDR_W-1:0] bus_addr,
   input wire logic register_select_n,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_data_in,
   output logic [7:0] bus_data_out,
   output logic bus_data_oe_n,
   // receive-side conditions
   input wire logic rx_polarity_reversed,
   input wire logic rx_table_search_active,
   input wire logic rx_carrier_lost,
   input wire logic rx_overlength_frame,
   input wire logic rx_line_code_error,
   input wire logic rx_missing_end_delimiter,
   input wire logic rx_missing_start_delimiter
);
   import fbest_pkg::*;

   fbest_timer_if tif ();

   logic wr_active;
   logic wr_prev_reg;
   logic wr_pulse;
   logic [7:0] error_status_reg;
   logic [NUM_TIMERS-1:0][15:0] snapshot_reg;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_next;
   logic [NUM_TIMERS-1:0] compare_we;

   // ------------------------------------------------------------
   // bus strobes
   // ------------------------------------------------------------
   // a write holds for several clocks; only its first cycle acts,
   // so a long strobe cannot clear a flag that is set again later
   assign wr_active = !register_select_n && bus_wr;
   assign wr_pulse = wr_active && !wr_prev_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_prev_reg <= 1'b0;
      end else if (clk_en) begin
         wr_prev_reg <= wr_active;
      end
   end

   // pin is driven only while a register read is in progress
   assign bus_data_oe_n = !(!register_select_n && bus_rd);
   assign bus_data_out = rd_data_reg;

   // ------------------------------------------------------------
   // receive error status
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         error_status_reg <= READ_ZERO;
      end else if (clk_en) begin
         error_status_reg <= READ_ZERO;
         error_status_reg[POLARITY_REVERSED_STATUS_BIT] <=
            rx_polarity_reversed;
         error_status_reg[TABLE_SEARCH_ACTIVE_STATUS_BIT] <=
            rx_table_search_active;
         error_status_reg[CARRIER_LOST_STATUS_BIT] <=
            rx_carrier_lost;
         error_status_reg[OVERLENGTH_FRAME_STATUS_BIT] <=
            rx_overlength_frame;
         error_status_reg[LINE_CODE_ERROR_STATUS_BIT] <=
            rx_line_code_error;
         error_status_reg[MISSING_END_DELIMITER_STATUS_BIT] <=
            rx_missing_end_delimiter;
         error_status_reg[MISSING_START_DELIMITER_STATUS_BIT] <=
            rx_missing_start_delimiter;
      end
   end

   // ------------------------------------------------------------
   // timer snapshot
   // ------------------------------------------------------------
   // all channels load together so a high/low byte pair always
   // belongs to one instant, however long the reads are spread
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         snapshot_reg <= '0;
      end else if (clk_en && wr_pulse && bus_addr == ADDR_SNAPSHOT) begin
         snapshot_reg <= tif.count;
      end
   end

   // ------------------------------------------------------------
   // writes toward the timer bank
   // ------------------------------------------------------------
   always_comb begin
      compare_we = '0;
      if (wr_pulse) begin
         unique case (bus_addr)
            ADDR_FINE_HI, ADDR_FINE_LO: begin
               compare_we[TIMER_FINE] = 1'b1;
            end
            ADDR_MS_HI, ADDR_MS_LO: begin
               compare_we[TIMER_MS] = 1'b1;
            end
            ADDR_BYTE_HI, ADDR_BYTE_LO: begin
               compare_we[TIMER_BYTE] = 1'b1;
            end
            default: begin
               compare_we = '0;
            end
         endcase
      end
   end

   assign tif.compare_we = compare_we;
   // even offset carries the high byte
   assign tif.compare_high = !bus_addr[0];
   assign tif.wdata = bus_data_in;
   assign tif.flag_clear = (wr_pulse && bus_addr == ADDR_TIMER_STATUS) ?
      bus_data_in[FLAG_W-1:0] : '0;

   fbest_timer_bank #(
      .MS_CYCLES(MS_CYCLES),
      .BYTE_CYCLES(BYTE_CYCLES)
   ) u_bank (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .tif(tif.bank)
   );

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_comb begin
      rd_next = READ_ZERO;
      unique case (bus_addr)
         ADDR_TIMER_STATUS: begin
            rd_next = {2'b00, tif.flags};
         end
         ADDR_ERROR_STATUS: begin
            rd_next = error_status_reg;
         end
         ADDR_FINE_HI: begin
            rd_next = snapshot_reg[TIMER_FINE][15:8];
         end
         ADDR_FINE_LO: begin
            rd_next = snapshot_reg[TIMER_FINE][7:0];
         end
         ADDR_MS_HI: begin
            rd_next = snapshot_reg[TIMER_MS][15:8];
         end
         ADDR_MS_LO: begin
            rd_next = snapshot_reg[TIMER_MS][7:0];
         end
         ADDR_BYTE_HI: begin
            rd_next = snapshot_reg[TIMER_BYTE][15:8];
         end
         ADDR_BYTE_LO: begin
            rd_next = snapshot_reg[TIMER_BYTE][7:0];
         end
         default: begin
            rd_next = READ_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_reg <= READ_ZERO;
      end else if (clk_en) begin
         rd_data_reg <= rd_next;
      end
   end

endmodule

// ### bench/fbest_host.sv
// host processor model that drives the slice's register bus
`timescale 1ns/1ps
module fbest_host (
   // clock
   input wire logic clk,
   // register bus toward the slice
   output logic [fbest_pkg::ADDR_W-1:0] bus_addr,
   output logic register_select_n,
   output logic bus_wr,
   output logic bus_rd,
   output logic [7:0] host_data,
   input wire logic [7:0] bus_data
);
   import fbest_pkg::*;
   initial begin
      bus_addr = 12'h0FF;
      register_select_n = 1'b1;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      host_data = 8'h5A;
   end
   // strobe drops for a cycle after each call, so every call is a new write
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      register_select_n <= 1'b0;
      bus_wr <= 1'b1;
      host_data <= d;
      @(posedge clk);
      register_select_n <= 1'b1;
      bus_wr <= 1'b0;
      host_data <= ~d;
   endtask
   // read data trails the address by a clock; it is taken mid-cycle,
   // where it has settled, not in the time step of a clock edge
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      register_select_n <= 1'b0;
      bus_rd <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      d = bus_data;
      @(posedge clk);
      register_select_n <= 1'b1;
      bus_rd <= 1'b0;
   endtask
   task automatic snapshot();
      wr_reg(ADDR_SNAPSHOT, 8'h01);
   endtask
   task automatic rd16(input logic [ADDR_W-1:0] a, output logic [15:0] v);
      rd_reg(a, v[15:8]);
      rd_reg(a + 12'h001, v[7:0]);
   endtask
endmodule

// ### bench/fbest_regs_asserts.sv
// concurrent checks on the register bus of the error and timer slice
`timescale 1ns/1ps
module fbest_regs_asserts #(
   parameter int MS_CYCLES = fbest_pkg::MS_TICK_CYCLES,
   parameter int BYTE_CYCLES = fbest_pkg::BYTE_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // host register bus
   input wire logic [fbest_pkg::ADDR_W-1:0] bus_addr,
   input wire logic register_select_n,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_data_in,
   input wire logic [7:0] bus_data_out,
   input wire logic bus_data_oe_n,
   // receive-side conditions
   input wire logic rx_polarity_reversed,
   input wire logic rx_table_search_active,
   input wire logic rx_carrier_lost,
   input wire logic rx_overlength_frame,
   input wire logic rx_line_code_error,
   input wire logic rx_missing_end_delimiter,
   input wire logic rx_missing_start_delimiter
);
   import fbest_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   logic snap_wr;
   assign snap_wr = !register_select_n && bus_wr && bus_addr == ADDR_SNAPSHOT;
   // status sampled while running, so the 1-clock input delay is known
   sequence s_read(logic [ADDR_W-1:0] a);
      clk_en && $past(clk_en) && $past(reset_n) && bus_addr == a;
   endsequence
   property p_oe_follows;
      bus_data_oe_n == !(!register_select_n && bus_rd);
   endproperty
   property p_oe_release;
      $rose(register_select_n) |-> bus_data_oe_n;
   endproperty
   property p_err_high;
      s_read(ADDR_ERROR_STATUS) |=> bus_data_out[7:6] ==
         {$past(rx_polarity_reversed, 2), $past(rx_table_search_active, 2)};
   endproperty
   property p_err_low;
      s_read(ADDR_ERROR_STATUS) |=> bus_data_out[4:0] ==
         {$past(rx_carrier_lost, 2), $past(rx_overlength_frame, 2),
          $past(rx_line_code_error, 2), $past(rx_missing_end_delimiter, 2),
          $past(rx_missing_start_delimiter, 2)};
   endproperty
   property p_err_gap;
      s_read(ADDR_ERROR_STATUS) |=> bus_data_out[5] == 1'b0;
   endproperty
   property p_snap_zero;
      s_read(ADDR_SNAPSHOT) |=> bus_data_out == READ_ZERO;
   endproperty
   property p_snap_hold;
      (clk_en && $past(clk_en) && $stable(bus_addr) && !$past(snap_wr) &&
       bus_addr inside {[ADDR_FINE_HI:ADDR_BYTE_LO]}) |=> $stable(bus_data_out);
   endproperty
   property p_tstat_top;
      s_read(ADDR_TIMER_STATUS) |=> bus_data_out[7:6] == 2'b00;
   endproperty
   a_oe_follows: assert property (p_oe_follows)
      else $error("data pin enable does not follow select and read");
   a_oe_release: assert property (p_oe_release)
      else $error("data pins still driven after deselect");
   a_err_high: assert property (p_err_high)
      else $error("error status upper bits wrong");
   a_err_low: assert property (p_err_low)
      else $error("error status lower bits wrong");
   a_err_gap: assert property (p_err_gap)
      else $error("unused error status bit not zero");
   a_snap_zero: assert property (p_snap_zero)
      else $error("snapshot trigger address reads nonzero");
   a_snap_hold: assert property (p_snap_hold)
      else $error("count read changed without a new snapshot");
   a_tstat_top: assert property (p_tstat_top)
      else $error("timer status upper bits not zero");
endmodule
bind fbest_regs fbest_regs_asserts #(.MS_CYCLES(MS_CYCLES),
   .BYTE_CYCLES(BYTE_CYCLES)) u_asserts (.clk(clk), .reset_n(reset_n),
   .clk_en(clk_en), .bus_addr(bus_addr),
   .register_select_n(register_select_n), .bus_wr(bus_wr),
   .bus_rd(bus_rd), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
   .bus_data_oe_n(bus_data_oe_n), .rx_polarity_reversed(rx_polarity_reversed),
   .rx_table_search_active(rx_table_search_active),
   .rx_carrier_lost(rx_carrier_lost),
   .rx_overlength_frame(rx_overlength_frame),
   .rx_line_code_error(rx_line_code_error),
   .rx_missing_end_delimiter(rx_missing_end_delimiter),
   .rx_missing_start_delimiter(rx_missing_start_delimiter));

// ### bench/fieldbus_error_status_and_timers_tb_top.sv
// self-checking bench for the error status and timer register slice
`timescale 1ns/1ps
module fieldbus_error_status_and_timers_tb_top;
   import fbest_pkg::*;
   localparam int MS_CYC = 40;
   // octet timer ticks every clock so that its wrap falls inside the run
   localparam int BYTE_CYC = 1;
   logic clk;
   logic reset_n;
   logic en;
   logic [ADDR_W-1:0] addr;
   logic sel_n;
   logic wr;
   logic rd;
   logic [7:0] hdata;
   logic [7:0] dout;
   logic [7:0] pins;
   logic oe_n;
   logic [6:0] rx;
   int num_errors = 0;
   int cmp_count = 0;
   // the pins carry the slice's byte while it drives, else the host's
   assign pins = oe_n ? hdata : dout;
   fbest_regs #(.MS_CYCLES(MS_CYC), .BYTE_CYCLES(BYTE_CYC)) dut (
      .clk(clk), .reset_n(reset_n), .clk_en(en), .bus_addr(addr),
      .register_select_n(sel_n), .bus_wr(wr), .bus_rd(rd),
      .bus_data_in(pins), .bus_data_out(dout), .bus_data_oe_n(oe_n),
      .rx_polarity_reversed(rx[6]), .rx_table_search_active(rx[5]),
      .rx_carrier_lost(rx[4]), .rx_overlength_frame(rx[3]),
      .rx_line_code_error(rx[2]), .rx_missing_end_delimiter(rx[1]),
      .rx_missing_start_delimiter(rx[0]));
   fbest_host host (.clk(clk), .bus_addr(addr), .register_select_n(sel_n),
      .bus_wr(wr), .bus_rd(rd), .host_data(hdata), .bus_data(pins));
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic t_reset();
      logic [7:0] d;
      host.rd_reg(ADDR_TIMER_STATUS, d);
      chk8(d, 8'h2A);
      host.rd_reg(ADDR_SNAPSHOT, d);
      chk8(d, READ_ZERO);
      $display("test reset done");
   endtask
   task automatic t_flags();
      logic [7:0] d;
      logic [7:0] w [3] = '{8'h02, 8'h00, 8'h28};
      logic [7:0] e [3] = '{8'h28, 8'h28, 8'h00};
      for (int i = 0; i < 3; i++) begin
         host.wr_reg(ADDR_TIMER_STATUS, w[i]);
         host.rd_reg(ADDR_TIMER_STATUS, d);
         chk8(d, e[i]);
      end
      $display("test flags done");
   endtask
   task automatic t_error();
      logic [7:0] d;
      for (int i = 0; i <= 8; i++) begin
         @(posedge clk);
         rx <= (i < 7) ? 7'(1 << i) : ((i == 7) ? 7'h7F : 7'h00);
         host.wr_reg(ADDR_ERROR_STATUS, 8'hFF);
         host.rd_reg(ADDR_ERROR_STATUS, d);
         chk8(d, {rx[6], rx[5], 1'b0, rx[4:0]});
      end
      $display("test error status done");
   endtask
   task automatic t_snapshot();
      logic [15:0] a, b, c, e, f;
      host.snapshot();
      host.rd16(ADDR_MS_HI, a);
      host.rd16(ADDR_BYTE_HI, e);
      repeat (200) @(posedge clk);
      host.rd16(ADDR_MS_HI, b);
      chk16(b, a);
      host.rd16(ADDR_BYTE_HI, b);
      chk16(b, e);
      host.snapshot();
      host.rd16(ADDR_MS_HI, c);
      host.rd16(ADDR_BYTE_HI, f);
      // 226 cycles lie between the two captures
      chk8({7'h00, (c - a) inside {16'h0005, 16'h0006}}, 8'h01);
      chk16(f - e, 16'h00E2);
      $display("test snapshot done");
   endtask
   // a low clock enable must stop the octet timer: 9 enabled edges
   // lie between the two captures, 100 frozen ones do not count
   task automatic t_freeze();
      logic [15:0] a, b;
      host.snapshot();
      host.rd16(ADDR_BYTE_HI, a);
      @(posedge clk);
      en <= 1'b0;
      repeat (100) @(posedge clk);
      en <= 1'b1;
      host.snapshot();
      host.rd16(ADDR_BYTE_HI, b);
      chk16(b - a, 16'h0009);
      $display("test freeze done");
   endtask
   task automatic t_wrap();
      logic [7:0] d;
      host.wr_reg(ADDR_TIMER_STATUS, 8'h3F);
      host.rd_reg(ADDR_TIMER_STATUS, d);
      chk8(d & 8'h10, 8'h00);
      // the octet count passes all ones near 65535 enabled cycles
      repeat (52000) @(posedge clk);
      host.rd_reg(ADDR_TIMER_STATUS, d);
      chk8(d & 8'h10, 8'h10);
      $display("test wrap done");
   endtask
   task automatic cmp_run(input logic [ADDR_W-1:0] ha, input logic [7:0] fl,
         input int per, input logic [15:0] ahead);
      logic [15:0] c;
      logic [7:0] d;
      host.snapshot();
      host.rd16(ha, c);
      c = c + ahead;
      host.wr_reg(ha, c[15:8]);
      host.wr_reg(ha + 12'h001, c[7:0]);
      host.wr_reg(ADDR_TIMER_STATUS, 8'h3F);
      host.rd_reg(ADDR_TIMER_STATUS, d);
      chk8(d & fl, 8'h00);
      repeat (per * (ahead + 1)) @(posedge clk);
      host.rd_reg(ADDR_TIMER_STATUS, d);
      chk8(d & fl, fl);
   endtask
   task automatic t_compare();
      cmp_run(ADDR_FINE_HI, 8'h02, FINE_TICK_CYCLES, 16'h0004);
      cmp_run(ADDR_MS_HI, 8'h08, MS_CYC, 16'h0004);
      // a fast timer runs past a near compare before the write lands
      cmp_run(ADDR_BYTE_HI, 8'h20, BYTE_CYC, 16'h0020);
      $display("test compare done");
   endtask
   task automatic final_report();
      $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      reset_n = 1'b0;
      en = 1'b1;
      rx = 7'h00;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_flags();
      t_error();
      t_snapshot();
      t_freeze();
      t_compare();
      t_wrap();
      final_report();
   end
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      final_report();
   end
endmodule
